// ==== logic/ihp_pkg.sv ====
package ihp_pkg;

  // ==========================================================================
  // Register map and fields.
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_RSA = 12'h004;
  localparam logic [11:0] APB_RBC = 12'h008;
  localparam logic [11:0] APB_SMC1 = 12'h00c;
  localparam logic [11:0] APB_SMC2 = 12'h010;
  localparam logic [11:0] APB_STAT = 12'h014;
  localparam int CTRL_WTS = 0;
  localparam int CTRL_ACK_DLY = 1;
  localparam int CTRL_RD_GO = 2;
  localparam int CTRL_WR_GO = 3;
  localparam int SMC1_EN = 6;
  localparam int SMC2_SIZE = 7;
  localparam logic [7:0] SMC1_RST = 8'h00;
  localparam logic [8:0] SMC2_RST = 9'h000;
  localparam logic [15:0] RSA_RST = 16'h0000;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

  // ==========================================================================
  // Host I/O decode and transfer constants.
  localparam logic [4:0] IO_BASE_HI = 5'h18;
  localparam int IO_PORT_BIT = 4;
  localparam logic [15:0] RBC_ZERO = 16'h0000;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [1:0] BE_LO = 2'h1;
  localparam logic [1:0] BE_HI = 2'h2;
  localparam logic [1:0] BE_BOTH = 2'h3;

  // ==========================================================================
  // State encodings.
  typedef enum logic [5:0] {
    RM_IDLE = 6'h01, RM_FETCH = 6'h02, RM_LOAD = 6'h04,
    RM_FULL = 6'h08, RM_EMPTY = 6'h10, RM_STORE = 6'h20
  } ihp_rm_t;
  typedef enum logic [3:0] {SM_IDLE = 4'h1, SM_WAIT = 4'h2, SM_DATA = 4'h4, SM_DONE = 4'h8} ihp_sm_t;
  typedef enum logic [3:0] {AR_NONE = 4'h1, AR_LOC = 4'h2, AR_SM = 4'h4, AR_REM = 4'h8} ihp_ar_t;

  // ==========================================================================
  // Shared helpers.
  function automatic logic [15:0] xfer_step(input logic wide);
    return wide ? STEP_WORD : STEP_BYTE;
  endfunction

  function automatic logic [15:0] count_after(input logic [15:0] cnt, input logic wide);
    return (cnt > xfer_step(wide)) ? (cnt - xfer_step(wide)) : RBC_ZERO;
  endfunction

  function automatic logic [5:0] base_mask(input logic [1:0] size);
    unique case (size)
      2'h0: return 6'h3f;
      2'h1: return 6'h3e;
      2'h2: return 6'h3c;
      2'h3: return 6'h38;
    endcase
  endfunction

  function automatic logic [15:0] offset_mask(input logic [1:0] size);
    unique case (size)
      2'h0: return 16'h1fff;
      2'h1: return 16'h3fff;
      2'h2: return 16'h7fff;
      2'h3: return 16'hffff;
    endcase
  endfunction

endpackage

// ==== logic/ihp_arb_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ihp_arb_if;
  logic loc_req;
  logic loc_gnt;
  logic sm_req;
  logic sm_gnt;
  logic rem_req;
  logic rem_gnt;
  modport arb (input loc_req, input sm_req, input rem_req,
               output loc_gnt, output sm_gnt, output rem_gnt);
  modport client (output loc_req, output sm_req, output rem_req,
                  input loc_gnt, input sm_gnt, input rem_gnt);
endinterface
`default_nettype wire

// ==== logic/ihp_smem_dec.sv ====
`timescale 1ns/1ps
`default_nettype none
module ihp_smem_dec (
  input wire logic [19:13] sa_i,
  input wire logic [23:17] la_i,
  input wire logic strap_i,
  input wire logic [7:0] ctrl1_i,
  input wire logic [8:0] ctrl2_i,
  output logic hit_o
);

  logic [5:0] mask;
  logic low_match;
  logic high_match;

  // ==========================================================================
  // Window decode.
  assign mask = ihp_pkg::base_mask(ctrl2_i[ihp_pkg::SMC2_SIZE +: 2]);
  assign low_match = ((sa_i[18:13] ^ ctrl1_i[5:0]) & mask) == 6'h00;
  // Narrow strap needs the top address bit set; wide strap compares the latched lines.
  assign high_match = strap_i ?
    ((la_i[23:20] == ctrl2_i[6:3]) && (la_i[18:17] == ctrl2_i[1:0])) :
    sa_i[19];
  assign hit_o = ctrl1_i[ihp_pkg::SMC1_EN] && low_match && high_match;

endmodule // ihp_smem_dec
`default_nettype wire

// ==== logic/ihp_arb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ihp_arb (
  input wire logic clk_i,
  input wire logic rst_i,
  ihp_arb_if.arb bus
);

  ihp_pkg::ihp_ar_t state_r;
  ihp_pkg::ihp_ar_t state_nxt;

  // ==========================================================================
  // Ownership of the buffer RAM.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ihp_pkg::AR_NONE:
        if (bus.loc_req) state_nxt = ihp_pkg::AR_LOC;
        else if (bus.sm_req) state_nxt = ihp_pkg::AR_SM;
        else if (bus.rem_req) state_nxt = ihp_pkg::AR_REM;
      ihp_pkg::AR_LOC: if (!bus.loc_req) state_nxt = ihp_pkg::AR_NONE;
      ihp_pkg::AR_SM: if (!bus.sm_req) state_nxt = ihp_pkg::AR_NONE;
      ihp_pkg::AR_REM: state_nxt = ihp_pkg::AR_NONE;
      default: state_nxt = ihp_pkg::AR_NONE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i) state_r <= ihp_pkg::AR_NONE;
    else state_r <= state_nxt;
  end

  assign bus.loc_gnt = (state_r == ihp_pkg::AR_LOC);
  assign bus.sm_gnt = (state_r == ihp_pkg::AR_SM);
  assign bus.rem_gnt = (state_r == ihp_pkg::AR_REM);

  // ==========================================================================
  // Checks.
  a_grant_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0({bus.loc_gnt, bus.sm_gnt, bus.rem_gnt})) else $error("two grants at once");
  a_rem_one_word: assert property (@(posedge clk_i) disable iff (rst_i)
    bus.rem_gnt |=> !bus.rem_gnt) else $error("remote grant held past one word");
  a_sm_keeps_ram: assert property (@(posedge clk_i) disable iff (rst_i)
    bus.sm_gnt && bus.sm_req |=> bus.sm_gnt && !bus.loc_gnt) else $error("host access preempted");
  a_loc_excludes: assert property (@(posedge clk_i) disable iff (rst_i)
    bus.loc_gnt && bus.loc_req |=> !bus.sm_gnt && !bus.rem_gnt) else $error("grant during local");
  c_loc_then_rem: cover property (@(posedge clk_i) disable iff (rst_i)
    bus.loc_gnt ##1 !bus.loc_gnt ##1 bus.rem_gnt);

endmodule // ihp_arb
`default_nettype wire

// ==== logic/ihp_top.sv ====
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Remote read fetches word, bumps address, count
// - Data port read stalls until latch filled
// - Read strobe acknowledges word, fetch next
// - Arbitrate per word, local DMA goes first
// - Block new port writes until latch stored
// - Each port write stored, address, count updated
// - Shared access waits while local DMA runs
// - Started shared access finishes before local
// - Shared memory answers only when enabled
// - Narrow strap: top address bit must be one
// - Base compare drops low bits per size
// - Wide strap uses both base registers
// - Memory cycles pass through memory bus
// - Register accesses are always byte wide
// - I/O decode on low lines, AEN ignores
// - Ready drops only while unable to answer
// - Registers and byte port use low lane
// - Wide mode flags wide acknowledge on port
// - Delay bit waits acknowledge for strobe
// - Word select bit sets transfer width
// - Word mode decrements count by two
module ihp_top (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [19:0] SA_I,
  input wire logic [23:17] LA_I,
  input wire logic AEN_I,
  input wire logic IORD_N_I,
  input wire logic IOWR_N_I,
  input wire logic MRD_N_I,
  input wire logic MWR_N_I,
  input wire logic SMRD_N_I,
  input wire logic SMWR_N_I,
  input wire logic SBHE_N_I,
  input wire logic [15:0] SD_I,
  output logic [15:0] SD_O,
  output logic [1:0] SD_OE_O,
  output logic CHRDY_O,
  output logic WIDE_IO_ACK_N_O,
  input wire logic BUS_WIDTH_STRAP_I,
  output logic [3:0] REG_ADDR_O,
  output logic [7:0] REG_WDATA_O,
  output logic REG_WR_O,
  output logic REG_RD_O,
  input wire logic [7:0] REG_RDATA_I,
  output logic [15:0] RAM_ADDR_O,
  output logic [15:0] RAM_WDATA_O,
  output logic [1:0] RAM_BE_O,
  output logic RAM_WE_O,
  output logic RAM_RE_O,
  input wire logic [15:0] RAM_RDATA_I,
  input wire logic LDMA_REQ_I,
  output logic LDMA_GNT_O
);

  // ==========================================================================
  // Arbiter and decoder.
  ihp_arb_if arb_bus ();
  logic sm_hit;
  logic [7:0] smc1_r;
  logic [8:0] smc2_r;

  ihp_arb u_arb (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .bus(arb_bus)
  );

  ihp_smem_dec u_dec (
    .sa_i(SA_I[19:13]),
    .la_i(LA_I),
    .strap_i(BUS_WIDTH_STRAP_I),
    .ctrl1_i(smc1_r),
    .ctrl2_i(smc2_r),
    .hit_o(sm_hit)
  );

  assign arb_bus.loc_req = LDMA_REQ_I;
  assign LDMA_GNT_O = arb_bus.loc_gnt;

  // ==========================================================================
  // Register file state.
  logic wts_r;
  logic ack_dly_r;
  logic [15:0] rem_addr_r;
  logic [15:0] rem_count_r;
  logic [31:0] prdata_r;
  ihp_pkg::ihp_rm_t rm_r;
  ihp_pkg::ihp_rm_t rm_nxt;
  ihp_pkg::ihp_sm_t sm_r;
  ihp_pkg::ihp_sm_t sm_nxt;

  // ==========================================================================
  // APB slave.
  logic apb_setup;
  logic apb_wr;
  logic sel_ctrl;
  logic sel_rsa;
  logic sel_rbc;
  logic sel_smc1;
  logic sel_smc2;
  logic sel_stat;
  logic apb_map;
  logic [31:0] apb_rdata;
  logic rd_go;
  logic wr_go;

  assign apb_setup = PSEL_I && !PENABLE_I;
  assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign sel_ctrl = (PADDR_I == ihp_pkg::APB_CTRL);
  assign sel_rsa = (PADDR_I == ihp_pkg::APB_RSA);
  assign sel_rbc = (PADDR_I == ihp_pkg::APB_RBC);
  assign sel_smc1 = (PADDR_I == ihp_pkg::APB_SMC1);
  assign sel_smc2 = (PADDR_I == ihp_pkg::APB_SMC2);
  assign sel_stat = (PADDR_I == ihp_pkg::APB_STAT);
  assign apb_map = sel_ctrl || sel_rsa || sel_rbc || sel_smc1 || sel_smc2 || sel_stat;
  assign apb_rdata = sel_ctrl ? {30'h0, ack_dly_r, wts_r} :
                     sel_rsa ? {16'h0, rem_addr_r} :
                     sel_rbc ? {16'h0, rem_count_r} :
                     sel_smc1 ? {24'h0, smc1_r} :
                     sel_smc2 ? {23'h0, smc2_r} :
                     sel_stat ? {22'h0, sm_r, rm_r} : ihp_pkg::RDATA_IDLE;
  assign rd_go = apb_wr && sel_ctrl && PWDATA_I[ihp_pkg::CTRL_RD_GO];
  assign wr_go = apb_wr && sel_ctrl && PWDATA_I[ihp_pkg::CTRL_WR_GO];
  assign PREADY_O = 1'h1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !apb_map;
  assign PRDATA_O = prdata_r;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      wts_r <= 1'h0;
      ack_dly_r <= 1'h0;
      smc1_r <= ihp_pkg::SMC1_RST;
      smc2_r <= ihp_pkg::SMC2_RST;
      prdata_r <= ihp_pkg::RDATA_IDLE;
    end
    else
    begin
      if (apb_setup) prdata_r <= apb_rdata;
      if (apb_wr && sel_ctrl) wts_r <= PWDATA_I[ihp_pkg::CTRL_WTS];
      if (apb_wr && sel_ctrl) ack_dly_r <= PWDATA_I[ihp_pkg::CTRL_ACK_DLY];
      if (apb_wr && sel_smc1) smc1_r <= PWDATA_I[7:0];
      if (apb_wr && sel_smc2) smc2_r <= PWDATA_I[8:0];
    end
  end

  // ==========================================================================
  // Host I/O decode.
  logic io_hit;
  logic io_rd;
  logic io_wr;
  logic port_rd;
  logic port_wr;
  logic reg_rd;
  logic reg_wr;
  logic port_rd_q_r;
  logic reg_rd_q_r;
  logic reg_wr_q_r;
  logic reg_rd_r;
  logic reg_wr_r;
  logic [3:0] reg_addr_r;
  logic [7:0] reg_wdata_r;
  logic port_rd_ack;
  logic port_wr_new;
  logic wr_taken_r;
  logic wide;

  assign wide = wts_r;
  assign io_hit = !AEN_I && (SA_I[9:5] == ihp_pkg::IO_BASE_HI);
  assign io_rd = io_hit && !IORD_N_I;
  assign io_wr = io_hit && !IOWR_N_I;
  assign port_rd = io_rd && SA_I[ihp_pkg::IO_PORT_BIT];
  assign port_wr = io_wr && SA_I[ihp_pkg::IO_PORT_BIT];
  assign reg_rd = io_rd && !SA_I[ihp_pkg::IO_PORT_BIT];
  assign reg_wr = io_wr && !SA_I[ihp_pkg::IO_PORT_BIT];
  assign port_rd_ack = port_rd_q_r && !port_rd;
  assign port_wr_new = port_wr && !wr_taken_r;
  assign REG_ADDR_O = reg_addr_r;
  assign REG_WDATA_O = reg_wdata_r;
  assign REG_RD_O = reg_rd_r;
  assign REG_WR_O = reg_wr_r;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      port_rd_q_r <= 1'h0;
      reg_rd_q_r <= 1'h0;
      reg_wr_q_r <= 1'h0;
      reg_rd_r <= 1'h0;
      reg_wr_r <= 1'h0;
      reg_addr_r <= 4'h0;
      reg_wdata_r <= 8'h00;
    end
    else
    begin
      port_rd_q_r <= port_rd;
      reg_rd_q_r <= reg_rd;
      reg_wr_q_r <= reg_wr;
      reg_rd_r <= reg_rd && !reg_rd_q_r;
      reg_wr_r <= reg_wr && !reg_wr_q_r;
      reg_addr_r <= SA_I[3:0];
      reg_wdata_r <= SD_I[7:0];
    end
  end

  // ==========================================================================
  // Remote DMA.
  logic st_fetch;
  logic st_full;
  logic st_empty;
  logic st_store;
  logic rem_step_en;
  logic lane_r;
  logic [15:0] latch_r;
  logic [15:0] rem_next_count;

  assign st_fetch = (rm_r == ihp_pkg::RM_FETCH);
  assign st_full = (rm_r == ihp_pkg::RM_FULL);
  assign st_empty = (rm_r == ihp_pkg::RM_EMPTY);
  assign st_store = (rm_r == ihp_pkg::RM_STORE);
  assign arb_bus.rem_req = st_fetch || st_store;
  assign rem_step_en = (st_fetch || st_store) && arb_bus.rem_gnt;
  assign rem_next_count = ihp_pkg::count_after(rem_count_r, wide);

  always_comb
  begin
    rm_nxt = rm_r;
    unique case (rm_r)
      ihp_pkg::RM_IDLE: rm_nxt = rm_r;
      ihp_pkg::RM_FETCH: if (arb_bus.rem_gnt) rm_nxt = ihp_pkg::RM_LOAD;
      ihp_pkg::RM_LOAD: rm_nxt = ihp_pkg::RM_FULL;
      ihp_pkg::RM_FULL:
        if (port_rd_ack)
          rm_nxt = (rem_count_r == ihp_pkg::RBC_ZERO) ? ihp_pkg::RM_IDLE : ihp_pkg::RM_FETCH;
      ihp_pkg::RM_EMPTY: if (port_wr_new) rm_nxt = ihp_pkg::RM_STORE;
      ihp_pkg::RM_STORE:
        if (arb_bus.rem_gnt)
          rm_nxt = (rem_next_count == ihp_pkg::RBC_ZERO) ? ihp_pkg::RM_IDLE : ihp_pkg::RM_EMPTY;
      default: rm_nxt = ihp_pkg::RM_IDLE;
    endcase
    if (rd_go)
      rm_nxt = (rem_count_r != ihp_pkg::RBC_ZERO) ? ihp_pkg::RM_FETCH : ihp_pkg::RM_IDLE;
    else if (wr_go)
      rm_nxt = (rem_count_r != ihp_pkg::RBC_ZERO) ? ihp_pkg::RM_EMPTY : ihp_pkg::RM_IDLE;
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      rm_r <= ihp_pkg::RM_IDLE;
      rem_addr_r <= ihp_pkg::RSA_RST;
      rem_count_r <= ihp_pkg::RBC_ZERO;
      latch_r <= 16'h0000;
      lane_r <= 1'h0;
      wr_taken_r <= 1'h0;
    end
    else
    begin
      rm_r <= rm_nxt;
      if (rem_step_en)
      begin
        rem_addr_r <= rem_addr_r + ihp_pkg::xfer_step(wide);
        rem_count_r <= rem_next_count;
      end
      else
      begin
        if (apb_wr && sel_rsa) rem_addr_r <= PWDATA_I[15:0];
        if (apb_wr && sel_rbc) rem_count_r <= PWDATA_I[15:0];
      end
      if (st_fetch) lane_r <= rem_addr_r[0];
      if (rm_r == ihp_pkg::RM_LOAD)
        latch_r <= wide ? RAM_RDATA_I : {8'h00, lane_r ? RAM_RDATA_I[15:8] : RAM_RDATA_I[7:0]};
      else if (st_empty && port_wr_new)
        latch_r <= wide ? SD_I : {8'h00, SD_I[7:0]};
      wr_taken_r <= port_wr && (wr_taken_r || (st_empty && port_wr_new));
    end
  end

  // ==========================================================================
  // Shared memory access.
  logic sm_strobe_rd;
  logic sm_strobe_wr;
  logic sm_cycle;
  logic sm_word;
  logic sm_op;
  logic [1:0] sm_be;
  logic [15:0] sm_off;

  assign sm_strobe_rd = BUS_WIDTH_STRAP_I ? !MRD_N_I : !SMRD_N_I;
  assign sm_strobe_wr = BUS_WIDTH_STRAP_I ? !MWR_N_I : !SMWR_N_I;
  assign sm_cycle = !AEN_I && sm_hit && (sm_strobe_rd || sm_strobe_wr);
  assign sm_word = BUS_WIDTH_STRAP_I && !SBHE_N_I && !SA_I[0];
  assign sm_be = sm_word ? ihp_pkg::BE_BOTH : (SA_I[0] ? ihp_pkg::BE_HI : ihp_pkg::BE_LO);
  assign sm_off = SA_I[15:0] & ihp_pkg::offset_mask(smc2_r[ihp_pkg::SMC2_SIZE +: 2]);
  assign arb_bus.sm_req = (sm_r == ihp_pkg::SM_WAIT);
  assign sm_op = (sm_r == ihp_pkg::SM_WAIT) && arb_bus.sm_gnt;

  always_comb
  begin
    sm_nxt = sm_r;
    unique case (sm_r)
      ihp_pkg::SM_IDLE: if (sm_cycle) sm_nxt = ihp_pkg::SM_WAIT;
      ihp_pkg::SM_WAIT:
        if (!sm_cycle) sm_nxt = ihp_pkg::SM_IDLE;
        else if (arb_bus.sm_gnt) sm_nxt = sm_strobe_rd ? ihp_pkg::SM_DATA : ihp_pkg::SM_DONE;
      ihp_pkg::SM_DATA: sm_nxt = ihp_pkg::SM_DONE;
      ihp_pkg::SM_DONE: if (!sm_cycle) sm_nxt = ihp_pkg::SM_IDLE;
      default: sm_nxt = ihp_pkg::SM_IDLE;
    endcase
  end

  // ==========================================================================
  // Memory support bus.
  logic [1:0] rem_be;

  assign rem_be = wide ? ihp_pkg::BE_BOTH : (rem_addr_r[0] ? ihp_pkg::BE_HI : ihp_pkg::BE_LO);
  assign RAM_RE_O = (st_fetch && arb_bus.rem_gnt) || (sm_op && sm_strobe_rd);
  assign RAM_WE_O = (st_store && arb_bus.rem_gnt) || (sm_op && !sm_strobe_rd);
  assign RAM_ADDR_O = sm_op ? sm_off : rem_addr_r;
  assign RAM_BE_O = sm_op ? sm_be : rem_be;
  assign RAM_WDATA_O = sm_op ? (sm_word ? SD_I : {SD_I[7:0], SD_I[7:0]}) :
                       (wide ? latch_r : {latch_r[7:0], latch_r[7:0]});

  // ==========================================================================
  // System data, ready and wide acknowledge.
  logic [15:0] sd_r;
  logic [1:0] sd_oe_r;
  logic io_wait;
  logic sm_wait;
  logic sm_rd_live;

  assign sm_rd_live = sm_cycle && sm_strobe_rd;

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      sm_r <= ihp_pkg::SM_IDLE;
      sd_r <= 16'h0000;
      sd_oe_r <= 2'h0;
    end
    else
    begin
      sm_r <= sm_nxt;
      if (sm_r == ihp_pkg::SM_DATA)
        sd_r <= sm_word ? RAM_RDATA_I : {8'h00, SA_I[0] ? RAM_RDATA_I[15:8] : RAM_RDATA_I[7:0]};
      else if (port_rd && st_full)
        sd_r <= wide ? latch_r : {8'h00, latch_r[7:0]};
      else if (reg_rd)
        sd_r <= {8'h00, REG_RDATA_I};
      sd_oe_r <= {(port_rd && wide) || (sm_rd_live && sm_word), io_rd || sm_rd_live};
    end
  end

  assign SD_O = sd_r;
  assign SD_OE_O = sd_oe_r;
  assign io_wait = (port_rd && !st_full) || (port_wr && !wr_taken_r && !st_empty);
  assign sm_wait = sm_cycle && (sm_r != ihp_pkg::SM_DONE);
  assign CHRDY_O = !(io_wait || sm_wait);
  assign WIDE_IO_ACK_N_O = !(wide && io_hit && SA_I[ihp_pkg::IO_PORT_BIT] &&
                      (!ack_dly_r || !IORD_N_I || !IOWR_N_I));

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_rd_stall: assert property (port_rd && !st_full |-> !CHRDY_O)
    else $error("port read not stalled while latch empty");
  a_fetch_step: assert property (st_fetch && arb_bus.rem_gnt && !rd_go && !wr_go |=>
    (rem_addr_r == $past(rem_addr_r) + ihp_pkg::xfer_step(wts_r)) ##1 st_full)
    else $error("fetch did not step address or fill latch");
  a_ack_refetch: assert property (st_full && port_rd_ack && !rd_go && !wr_go &&
    (rem_count_r != ihp_pkg::RBC_ZERO) |=> st_fetch) else $error("ack did not start next fetch");
  a_zero_stop: assert property (st_full && port_rd_ack && !rd_go && !wr_go &&
    (rem_count_r == ihp_pkg::RBC_ZERO) |=> !arb_bus.rem_req [*2]) else $error("request after zero");
  a_wr_block: assert property (port_wr && !wr_taken_r && !st_empty |-> !CHRDY_O)
    else $error("port write not held off");
  a_store_write: assert property (st_store && arb_bus.rem_gnt |-> RAM_WE_O &&
    (RAM_ADDR_O == rem_addr_r)) else $error("store did not write latched data");
  a_word_step: assert property (rem_step_en && wts_r &&
    (rem_count_r > ihp_pkg::STEP_WORD) && !rd_go && !wr_go |=>
    (rem_count_r == $past(rem_count_r) - ihp_pkg::STEP_WORD)) else $error("word count step wrong");
  a_smem_enable: assert property (!smc1_r[ihp_pkg::SMC1_EN] |-> !sm_hit && !sm_op)
    else $error("shared memory answered while disabled");
  a_sm_wait: assert property (sm_cycle && arb_bus.loc_gnt &&
    (sm_r != ihp_pkg::SM_DONE) |-> !CHRDY_O)
    else $error("shared access ready during local transfer");
  a_ack_delay: assert property (ack_dly_r && IORD_N_I && IOWR_N_I |-> WIDE_IO_ACK_N_O)
    else $error("wide acknowledge before strobe");
  a_aen_ignore: assert property (AEN_I [*2] |=> !REG_RD_O && !REG_WR_O)
    else $error("register strobe while AEN high");
  c_read_word: cover property (st_full ##1 port_rd ##[1:20] st_fetch);
  c_sm_waited: cover property (sm_cycle && !CHRDY_O ##[1:50] CHRDY_O);
  c_store: cover property (st_store && arb_bus.rem_gnt);

endmodule // ihp_top
`default_nettype wire

// ==== testbench/ihp_ram_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Buffer RAM on the memory support bus; byte at address a holds a.
module ihp_ram_model (
  input wire logic clk_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] be_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [0:63];
  initial
  begin
    for (int i = 0; i < 64; i++)
      mem[i] = {8'(2 * i + 1), 8'(2 * i)};
  end
  // Read data is valid one cycle after the read pulse, otherwise it toggles.
  always @(posedge clk_i)
  begin
    if (we_i && be_i[0])
      mem[addr_i[6:1]][7:0] <= wdata_i[7:0];
    if (we_i && be_i[1])
      mem[addr_i[6:1]][15:8] <= wdata_i[15:8];
    rdata_o <= re_i ? mem[addr_i[6:1]] : ~rdata_o;
  end
endmodule // ihp_ram_model
`default_nettype wire

// ==== testbench/isa_host_data_port_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module isa_host_data_port_test;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, perr, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [19:0] sa = 20'h0;
  logic aen = 1'b0, iord_n = 1'b1, iowr_n = 1'b1, smrd_n = 1'b1, sbhe_n = 1'b1, ldma = 1'b0;
  logic [7:0] wr_seen = 8'h00;
  logic [15:0] sd_i = 16'h0, sd_o, ram_addr, ram_wdata, ram_rdata;
  logic [1:0] sd_oe, oe, ram_be;
  logic chrdy, wide_io_ack_n, reg_wr, reg_rd, ram_we, ram_re, ldma_gnt, saw16, sawlo;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  int failures = 0, cmp_count = 0, rd_pulses = 0;
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (reg_rd === 1'b1) rd_pulses <= rd_pulses + 1;
  always @(posedge clk) if (reg_wr === 1'b1) wr_seen <= reg_wdata;
  ihp_top dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .SA_I(sa), .LA_I(7'h00), .AEN_I(aen), .IORD_N_I(iord_n),
    .IOWR_N_I(iowr_n), .MRD_N_I(1'b1), .MWR_N_I(1'b1), .SMRD_N_I(smrd_n), .SMWR_N_I(1'b1),
    .SBHE_N_I(sbhe_n), .SD_I(sd_i), .SD_O(sd_o), .SD_OE_O(sd_oe), .CHRDY_O(chrdy),
    .WIDE_IO_ACK_N_O(wide_io_ack_n), .BUS_WIDTH_STRAP_I(1'b0), .REG_ADDR_O(reg_addr),
    .REG_WDATA_O(reg_wdata), .REG_WR_O(reg_wr), .REG_RD_O(reg_rd),
    .REG_RDATA_I({4'ha, reg_addr}), .RAM_ADDR_O(ram_addr), .RAM_WDATA_O(ram_wdata),
    .RAM_BE_O(ram_be), .RAM_WE_O(ram_we), .RAM_RE_O(ram_re), .RAM_RDATA_I(ram_rdata),
    .LDMA_REQ_I(ldma), .LDMA_GNT_O(ldma_gnt));
  ihp_ram_model ram (.clk_i(clk), .addr_i(ram_addr), .wdata_i(ram_wdata), .be_i(ram_be),
    .we_i(ram_we), .re_i(ram_re), .rdata_o(ram_rdata));
  // ========================================================================
  // Shared tasks.
  task report_and_stop;
    $display("Counts: %0d compares, %0d failures", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task tmo(input logic ok);
    if (!ok)
    begin
      failures++;
      $display("Error wait expected done seen timeout");
      report_and_stop();
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    tmo(n < 20);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task isa(input int k, input logic [19:0] a, input logic [15:0] d, output logic [15:0] q);
    int n, hi;
    @(posedge clk);
    sa <= a;
    sd_i <= d;
    iord_n <= (k != 0);
    iowr_n <= (k != 1);
    smrd_n <= (k != 2);
    hi = 0;
    saw16 = 1'b0;
    sawlo = 1'b0;
    for (n = 0; n < 60 && hi < 4; n++)
    begin
      @(negedge clk);
      hi = (chrdy === 1'b1) ? hi + 1 : 0;
      sawlo = sawlo | (chrdy !== 1'b1);
      saw16 = saw16 | (wide_io_ack_n === 1'b0);
    end
    tmo(hi == 4);
    q = sd_o;
    oe = sd_oe;
    @(posedge clk);
    iord_n <= 1'b1;
    iowr_n <= 1'b1;
    smrd_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // ========================================================================
  // Scenarios.
  task t_apb;
    logic [31:0] q;
    apb(1'b0, ihp_pkg::APB_SMC1, 32'h0, q);
    chk("smc1 reset", 32'(ihp_pkg::SMC1_RST), q);
    apb(1'b1, ihp_pkg::APB_RBC, 32'h1234, q);
    apb(1'b0, ihp_pkg::APB_RBC, 32'h0, q);
    chk("rbc", 32'h1234, q);
    apb(1'b0, 12'h018, 32'h0, q);
    chk("unmapped err", 32'h1, {31'h0, perr});
    $display("Test apb done");
  endtask
  task t_rread;
    logic [31:0] q;
    logic [15:0] d;
    apb(1'b1, ihp_pkg::APB_RSA, 32'h11, q);
    apb(1'b1, ihp_pkg::APB_RBC, 32'h2, q);
    apb(1'b1, ihp_pkg::APB_CTRL, 32'h4, q);
    isa(0, 20'h00310, 16'h0, d);
    chk("port byte 0", 32'h11, {24'h0, d[7:0]});
    chk("read stalled", 32'h1, {31'h0, sawlo});
    chk("low lane", 32'h1, {30'h0, oe});
    isa(0, 20'h00310, 16'h0, d);
    chk("port byte 1", 32'h12, {24'h0, d[7:0]});
    apb(1'b0, ihp_pkg::APB_RSA, 32'h0, q);
    chk("address", 32'h13, q);
    apb(1'b0, ihp_pkg::APB_STAT, 32'h0, q);
    chk("idle at zero", 32'h1, {26'h0, q[5:0]});
    $display("Test remote read done");
  endtask
  task t_wwrite;
    logic [31:0] q;
    logic [15:0] d;
    apb(1'b1, ihp_pkg::APB_RSA, 32'h20, q);
    apb(1'b1, ihp_pkg::APB_RBC, 32'h4, q);
    apb(1'b1, ihp_pkg::APB_CTRL, 32'hb, q);
    sbhe_n <= 1'b0;
    isa(1, 20'h00310, 16'hbeef, d);
    chk("wide ack", 32'h1, {31'h0, saw16});
    isa(1, 20'h00310, 16'h1234, d);
    apb(1'b0, ihp_pkg::APB_RBC, 32'h0, q);
    chk("count by two", 32'h0, q);
    chk("word 0", 32'hbeef, {16'h0, ram.mem[16]});
    chk("word 1", 32'h1234, {16'h0, ram.mem[17]});
    apb(1'b1, ihp_pkg::APB_CTRL, 32'h0, q);
    sbhe_n <= 1'b1;
    $display("Test remote write done");
  endtask
  task t_aen;
    logic [15:0] d;
    int n;
    n = rd_pulses;
    aen <= 1'b1;
    isa(0, 20'h00305, 16'h0, d);
    chk("aen ignored", 32'(n), 32'(rd_pulses));
    aen <= 1'b0;
    isa(0, 20'h00305, 16'h0, d);
    chk("reg byte", 32'ha5, {24'h0, d[7:0]});
    chk("no wait", 32'h0, {31'h0, sawlo});
    isa(1, 20'h00305, 16'h125a, d);
    chk("reg write", 32'h5a, {24'h0, wr_seen});
    $display("Test register done");
  endtask
  task t_smem;
    logic [31:0] q;
    logic [15:0] d;
    apb(1'b1, ihp_pkg::APB_SMC1, 32'h01, q);
    isa(2, 20'h82020, 16'h0, d);
    chk("smem off", 32'h0, {31'h0, sawlo});
    apb(1'b1, ihp_pkg::APB_SMC1, 32'h41, q);
    isa(2, 20'h82020, 16'h0, d);
    chk("smem wait", 32'h1, {31'h0, sawlo});
    chk("smem data", 32'hef, {24'h0, d[7:0]});
    ldma <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("local grant", 32'h1, {31'h0, ldma_gnt});
    fork
      isa(2, 20'h82020, 16'h0, d);
      begin
        repeat (8) @(negedge clk);
        chk("smem held", 32'h0, {31'h0, chrdy});
        @(posedge clk);
        ldma <= 1'b0;
      end
    join
    chk("smem after local", 32'hef, {24'h0, d[7:0]});
    isa(2, 20'h02020, 16'h0, d);
    chk("a19 low", 32'h0, {31'h0, sawlo});
    $display("Test shared memory done");
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_apb();
    t_rread();
    t_wwrite();
    t_aen();
    t_smem();
    report_and_stop();
  end
endmodule // isa_host_data_port_test
`default_nettype wire
